//--- rps_board_model.sv
// Purpose: Board and probe model seen at the pads of the controller.
// Assumes: A pad driven by the controller shows the driven level.
// Notes:   A floating pad toggles each cycle, so a stale level never passes.
`timescale 1ns/100ps
module rps_board_model (
	input  wire logic                         ref_clk,
	input  wire logic [rps_pkg::NUM_PADS-1:0] pad_oe,
	input  wire logic [rps_pkg::NUM_PADS-1:0] pad_out,
	input  wire logic [rps_pkg::NUM_PADS-1:0] pad_pd,
	output logic      [rps_pkg::NUM_PADS-1:0] pad_in
);
	logic [rps_pkg::NUM_PADS-1:0] flip_r = 13'h0AAA;
	logic [rps_pkg::NUM_PADS-1:0] flip_nxt;

	// The real level of an open pad is unknown, so it keeps changing.
	always_comb begin
		flip_nxt = ~flip_r;
		pad_in   = (pad_oe & pad_out) | (~pad_oe & ~pad_pd & flip_r);
	end

	// Registers the changing pattern.
	always_ff @(posedge ref_clk) begin
		flip_r <= flip_nxt;
	end
endmodule

//--- rps_pad_ctrl.sv
// Purpose: Decides pad function, direction, level, pull-down and input gating
//          across reset, release and the power save modes.
// Assumes: Reset sources and power mode arrive as levels synchronous to ref_clk;
//          rst_n is the controller's own power-up reset only.
// Notes:   Pad bit 0 is the shared debug-reset port pin, bits 1 to 4 are debug
//          data in, data out, clock and mode select, bits 5 and up are port pads.
`timescale 1ns/100ps

// Behaviour
// - During external reset or power-on-clear: shared pad input with pull-down, rest floating.
// - After external reset: debug pads take debug functions, data out drives.
// - After external reset: all non-debug pads become input port pins.
// - After power-on-clear: every pad, debug ones included, becomes an input port pin.
// - Other internal resets keep debug pads as before; other pads become inputs.
// - Halt mode changes nothing at any pad.
// - In idle and stop, outputs keep the level they had on entry.
// - In idle and stop, wake-capable inputs stay live, all others are ignored.
// - Wake-capable means fifteen external interrupts, non-maskable interrupt, four CAN receives.
// - Leaving idle or stop restores every pad to its pre-entry setup.
module rps_pad_ctrl (
	input  wire logic                           ref_clk,
	input  wire logic                           rst_n,
	input  wire logic                           ext_reset,
	input  wire logic                           poc_reset,
	input  wire logic                           int_reset,
	input  wire logic [1:0]                     pwr_mode,
	input  wire logic                           cfg_wr,
	input  wire logic [rps_pkg::NUM_PADS-1:0]   req_func,
	input  wire logic [rps_pkg::NUM_PADS-1:0]   req_oe,
	input  wire logic [rps_pkg::NUM_PADS-1:0]   req_out,
	input  wire logic [rps_pkg::NUM_PADS-1:0]   req_pd,
	input  wire logic [rps_pkg::NUM_PADS-1:0]   pad_in,
	input  wire logic [rps_pkg::WAKE_NUM-1:0]   wake_in,
	output logic      [rps_pkg::NUM_PADS-1:0]   pad_func,
	output logic      [rps_pkg::NUM_PADS-1:0]   pad_oe,
	output logic      [rps_pkg::NUM_PADS-1:0]   pad_out,
	output logic      [rps_pkg::NUM_PADS-1:0]   pad_pd,
	output logic      [rps_pkg::NUM_PADS-1:0]   pad_ie,
	output logic      [rps_pkg::NUM_PADS-1:0]   core_in,
	output logic      [rps_pkg::WAKE_NUM-1:0]   wake_out,
	output rps_pkg::rps_rsrc_e                  rst_src,
	output logic                                cfg_hold
);

	rps_pkg::rps_state_e                state_r;
	rps_pkg::rps_state_e                state_nxt;
	rps_pkg::rps_rsrc_e                 rsrc_r;
	rps_pkg::rps_rsrc_e                 rsrc_nxt;
	logic                               hold_r;
	logic                               hold_nxt;
	logic [rps_pkg::NUM_PADS-1:0]       func_r;
	logic [rps_pkg::NUM_PADS-1:0]       func_nxt;
	logic [rps_pkg::NUM_PADS-1:0]       oe_r;
	logic [rps_pkg::NUM_PADS-1:0]       oe_nxt;
	logic [rps_pkg::NUM_PADS-1:0]       out_r;
	logic [rps_pkg::NUM_PADS-1:0]       out_nxt;
	logic [rps_pkg::NUM_PADS-1:0]       pd_r;
	logic [rps_pkg::NUM_PADS-1:0]       pd_nxt;
	logic [rps_pkg::NUM_PADS-1:0]       ie_r;
	logic [rps_pkg::NUM_PADS-1:0]       ie_nxt;
	logic [rps_pkg::NUM_PADS-1:0]       cin_r;
	logic [rps_pkg::NUM_PADS-1:0]       cin_nxt;
	logic [rps_pkg::WAKE_NUM-1:0]       wake_r;
	logic [rps_pkg::WAKE_NUM-1:0]       wake_nxt;
	logic                               any_rst;
	logic                               save_req;
	logic                               hard_rst;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Reset source decode; power-on-clear outranks the external pin, which outranks the rest.
	assign any_rst  = ext_reset | poc_reset | int_reset;
	assign hard_rst = ext_reset | poc_reset;
	assign save_req = (pwr_mode == rps_pkg::PM_IDLE) || (pwr_mode == rps_pkg::PM_STOP);

	// Sequencer and reset source latch. Halt is treated as run on purpose, since
	// only the processor stops and the pads must not notice.
	always_comb begin
		state_nxt = state_r;
		rsrc_nxt  = rsrc_r;
		hold_nxt  = hold_r;
		if (any_rst) begin
			state_nxt = rps_pkg::ST_RESET;
			if (poc_reset) begin
				rsrc_nxt = rps_pkg::RS_POC;
			end else if (ext_reset) begin
				rsrc_nxt = rps_pkg::RS_EXT;
			end else begin
				rsrc_nxt = rps_pkg::RS_INT;
			end
		end else begin
			case (state_r)
				rps_pkg::ST_RESET: begin
					state_nxt = rps_pkg::ST_RUN;
					hold_nxt  = 1'b1;
				end
				rps_pkg::ST_RUN: begin
					if (save_req) begin
						state_nxt = rps_pkg::ST_SAVE;
					end else if (cfg_wr) begin
						hold_nxt = 1'b0;
					end
				end
				rps_pkg::ST_SAVE: begin
					if (!save_req) begin
						state_nxt = rps_pkg::ST_RUN;
					end
				end
				default: begin
					state_nxt = rps_pkg::ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= rps_pkg::ST_RESET;
			rsrc_r  <= rps_pkg::RS_POC;
			hold_r  <= 1'b1;
		end else begin
			state_r <= state_nxt;
			rsrc_r  <= rsrc_nxt;
			hold_r  <= hold_nxt;
		end
	end

	// Pad setup. While held after a release the pads keep their release setup until
	// the port logic writes a new one; otherwise they follow the requested setup.
	always_comb begin
		func_nxt = func_r;
		oe_nxt   = oe_r;
		out_nxt  = out_r;
		pd_nxt   = pd_r;
		ie_nxt   = ie_r;
		if (any_rst) begin
			if (hard_rst) begin
				func_nxt = rps_pkg::PAD_NONE;
				oe_nxt   = rps_pkg::PAD_NONE;
				out_nxt  = rps_pkg::PAD_NONE;
				ie_nxt   = rps_pkg::SHARED_MASK;
				pd_nxt   = rps_pkg::SHARED_MASK;
			end else begin
				// Debug pads untouched so an attached probe keeps access.
				func_nxt = func_r & rps_pkg::DBG_MASK;
				oe_nxt   = oe_r & rps_pkg::DBG_MASK;
				out_nxt  = out_r & rps_pkg::DBG_MASK;
				ie_nxt   = ie_r & rps_pkg::DBG_MASK;
				pd_nxt   = pd_r & rps_pkg::DBG_MASK;
			end
		end else begin
			case (state_r)
				rps_pkg::ST_RESET: begin
					case (rsrc_r)
						rps_pkg::RS_EXT: begin
							func_nxt = rps_pkg::DBG_MASK;
							oe_nxt   = rps_pkg::DDO_MASK;
							out_nxt  = rps_pkg::PAD_NONE;
							ie_nxt   = rps_pkg::DBG_IN_MASK | rps_pkg::SHARED_MASK
								| rps_pkg::GEN_MASK;
							pd_nxt   = rps_pkg::SHARED_MASK;
						end
						rps_pkg::RS_INT: begin
							func_nxt = func_r & rps_pkg::DBG_MASK;
							oe_nxt   = oe_r & rps_pkg::DBG_MASK;
							out_nxt  = out_r & rps_pkg::DBG_MASK;
							ie_nxt   = (ie_r & rps_pkg::DBG_MASK) | rps_pkg::GEN_MASK;
							pd_nxt   = pd_r & rps_pkg::DBG_MASK;
						end
						default: begin
							func_nxt = rps_pkg::PAD_NONE;
							oe_nxt   = rps_pkg::PAD_NONE;
							out_nxt  = rps_pkg::PAD_NONE;
							ie_nxt   = rps_pkg::PAD_ALL;
							pd_nxt   = rps_pkg::PAD_NONE;
						end
					endcase
				end
				rps_pkg::ST_RUN: begin
					// Entering idle or stop freezes the setup, which is also what leaving restores.
					if (!save_req && (!hold_r || cfg_wr)) begin
						func_nxt = req_func;
						oe_nxt   = req_oe;
						out_nxt  = req_out;
						pd_nxt   = req_pd;
						ie_nxt   = ~req_oe;
					end
				end
				rps_pkg::ST_SAVE: begin
					func_nxt = func_r;
					oe_nxt   = oe_r;
					out_nxt  = out_r;
				end
				default: begin
					func_nxt = func_r;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			func_r <= rps_pkg::PAD_NONE;
			oe_r   <= rps_pkg::PAD_NONE;
			out_r  <= rps_pkg::PAD_NONE;
			pd_r   <= rps_pkg::SHARED_MASK;
			ie_r   <= rps_pkg::SHARED_MASK;
		end else begin
			func_r <= func_nxt;
			oe_r   <= oe_nxt;
			out_r  <= out_nxt;
			pd_r   <= pd_nxt;
			ie_r   <= ie_nxt;
		end
	end

	// Input gating. Ordinary inputs are blocked in reset and power save; the wake
	// inputs stay open in power save so that an interrupt can end it.
	always_comb begin
		cin_nxt  = rps_pkg::PAD_NONE;
		wake_nxt = rps_pkg::WAKE_NONE;
		if (!any_rst && state_r != rps_pkg::ST_RESET) begin
			wake_nxt = wake_in;
			if (state_r == rps_pkg::ST_RUN) begin
				cin_nxt = pad_in & ie_r;
			end else begin
				cin_nxt = rps_pkg::PAD_NONE;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cin_r  <= rps_pkg::PAD_NONE;
			wake_r <= rps_pkg::WAKE_NONE;
		end else begin
			cin_r  <= cin_nxt;
			wake_r <= wake_nxt;
		end
	end

	// Outputs straight from the flip-flops.
	assign pad_func = func_r;
	assign pad_oe   = oe_r;
	assign pad_out  = out_r;
	assign pad_pd   = pd_r;
	assign pad_ie   = ie_r;
	assign core_in  = cin_r;
	assign wake_out = wake_r;
	assign rst_src  = rsrc_r;
	assign cfg_hold = hold_r;

	// Checks on the reset, release and power save behaviour.
	property p_hard_rst_pads;
		hard_rst |=> pad_oe == rps_pkg::PAD_NONE && pad_ie == rps_pkg::SHARED_MASK
			&& pad_pd == rps_pkg::SHARED_MASK;
	endproperty
	a_hard_rst_pads: assert property (p_hard_rst_pads) else $error("pads not floating in reset");

	property p_ext_rel_dbg;
		state_r == rps_pkg::ST_RESET && !any_rst && rsrc_r == rps_pkg::RS_EXT
			|=> pad_func == rps_pkg::DBG_MASK && pad_oe == rps_pkg::DDO_MASK;
	endproperty
	a_ext_rel_dbg: assert property (p_ext_rel_dbg) else $error("debug pads wrong after ext reset");

	property p_ext_rel_gen;
		state_r == rps_pkg::ST_RESET && !any_rst && rsrc_r == rps_pkg::RS_EXT
			|=> (pad_ie & rps_pkg::GEN_MASK) == rps_pkg::GEN_MASK
			&& (pad_func & rps_pkg::GEN_MASK) == rps_pkg::PAD_NONE;
	endproperty
	a_ext_rel_gen: assert property (p_ext_rel_gen) else $error("port pads not inputs");

	property p_poc_rel;
		state_r == rps_pkg::ST_RESET && !any_rst && rsrc_r == rps_pkg::RS_POC
			|=> pad_ie == rps_pkg::PAD_ALL && pad_func == rps_pkg::PAD_NONE ##1 cfg_hold;
	endproperty
	a_poc_rel: assert property (p_poc_rel) else $error("pads not inputs after power-on");

	property p_int_keep;
		state_r == rps_pkg::ST_RUN && int_reset && !hard_rst
			|=> $stable(pad_func & rps_pkg::DBG_MASK) && $stable(pad_oe & rps_pkg::DBG_MASK);
	endproperty
	a_int_keep: assert property (p_int_keep) else $error("debug pads lost on internal reset");

	property p_halt;
		pwr_mode == rps_pkg::PM_HALT && state_r == rps_pkg::ST_RUN && hold_r && !cfg_wr
			&& !any_rst |=> $stable(pad_oe) && $stable(pad_func) && $stable(pad_out);
	endproperty
	a_halt: assert property (p_halt) else $error("halt disturbed pads");

	property p_save_hold;
		state_r == rps_pkg::ST_SAVE && !any_rst |=> $stable(pad_oe) && $stable(pad_out);
	endproperty
	a_save_hold: assert property (p_save_hold) else $error("output changed in power save");

	property p_save_gate;
		state_r == rps_pkg::ST_SAVE && !any_rst |=> core_in == rps_pkg::PAD_NONE
			&& wake_out == $past(wake_in);
	endproperty
	a_save_gate: assert property (p_save_gate) else $error("input gating wrong in save");

	// The setup is frozen for the whole stay in save, so an exit that moves nothing
	// restores the setup of entry however long the stay lasted.
	property p_save_exit;
		state_r == rps_pkg::ST_SAVE && !save_req && !any_rst |=> $stable(pad_func)
			&& $stable(pad_oe) && $stable(pad_out) && $stable(pad_pd) && $stable(pad_ie);
	endproperty
	a_save_exit: assert property (p_save_exit) else $error("setup not restored");

	property p_src_latch;
		poc_reset |=> rst_src == rps_pkg::RS_POC;
	endproperty
	a_src_latch: assert property (p_src_latch) else $error("reset source not latched");

	c_ext_release: cover property (state_r == rps_pkg::ST_RESET && !any_rst
		&& rsrc_r == rps_pkg::RS_EXT);
	c_int_release: cover property (state_r == rps_pkg::ST_RESET && !any_rst
		&& rsrc_r == rps_pkg::RS_INT);
	c_save_cycle: cover property (state_r == rps_pkg::ST_SAVE ##1 state_r == rps_pkg::ST_RUN);

endmodule

//--- rps_pkg.sv
// Purpose: Shared constants and types for the reset and power save pad state controller.
// Assumes: Thirteen pads, five of them forming the debug port group at the low indices.
// Notes:   Masks select pad groups; bit 0 is the shared debug-reset port pin.
package rps_pkg;

	// Pad group sizes and positions.
	localparam int DBG_PADS  = 5;
	localparam int GEN_PADS  = 8;
	localparam int NUM_PADS  = DBG_PADS + GEN_PADS;

	// Wake-capable inputs: external interrupts, non-maskable interrupt, CAN receive.
	localparam int EXTINT_NUM = 15;
	localparam int NMI_NUM    = 1;
	localparam int CANRX_NUM  = 4;
	localparam int WAKE_NUM   = EXTINT_NUM + NMI_NUM + CANRX_NUM;

	// Pad group masks.
	localparam logic [NUM_PADS-1:0] PAD_NONE     = 13'h0000;
	localparam logic [NUM_PADS-1:0] PAD_ALL      = 13'h1FFF;
	localparam logic [NUM_PADS-1:0] SHARED_MASK  = 13'h0001;
	localparam logic [NUM_PADS-1:0] DBG_IN_MASK  = 13'h001A;
	localparam logic [NUM_PADS-1:0] DDO_MASK     = 13'h0004;
	localparam logic [NUM_PADS-1:0] DBG_MASK     = 13'h001F;
	localparam logic [NUM_PADS-1:0] GEN_MASK     = 13'h1FE0;
	localparam logic [WAKE_NUM-1:0] WAKE_NONE    = 20'h00000;

	// Power mode encoding on the pwr_mode input.
	localparam logic [1:0] PM_RUN  = 2'h0;
	localparam logic [1:0] PM_HALT = 2'h1;
	localparam logic [1:0] PM_IDLE = 2'h2;
	localparam logic [1:0] PM_STOP = 2'h3;

	typedef enum logic [1:0] {RS_NONE, RS_EXT, RS_POC, RS_INT} rps_rsrc_e;
	typedef enum logic [1:0] {ST_RUN, ST_RESET, ST_SAVE} rps_state_e;

endpackage

//--- test_reset_powersave_pin_state_ctrl.sv
// Purpose: Self-checking bench for the reset and power save pad controller.
// Assumes: Release setups settle within three cycles.
// Notes:   Checks wait spare cycles, so exact latency is not at stake.
`timescale 1ns/100ps
module test_reset_powersave_pin_state_ctrl;
	localparam int           N    = rps_pkg::NUM_PADS;
	localparam logic [N-1:0] DM   = rps_pkg::DBG_MASK;
	localparam logic [N-1:0] GM   = rps_pkg::GEN_MASK;
	localparam logic [N-1:0] SH   = rps_pkg::SHARED_MASK;
	localparam logic [N-1:0] OE1  = rps_pkg::DDO_MASK | GM;
	localparam logic [N-1:0] OUT1 = 13'h1544;
	logic               ref_clk, rst_n, ext_reset, poc_reset, int_reset, cfg_wr, cfg_hold;
	logic [1:0]         pwr_mode;
	logic [N-1:0]       req_func, req_oe, req_out, req_pd, pad_in;
	logic [N-1:0]       pad_func, pad_oe, pad_out, pad_pd, pad_ie, core_in;
	logic [19:0]        wake_in, wake_out;
	rps_pkg::rps_rsrc_e rst_src;
	int                 mismatches, comparisons;

	// The controller and the board around it.
	rps_pad_ctrl rps_pad_ctrl_inst (.ref_clk, .rst_n, .ext_reset, .poc_reset, .int_reset,
		.pwr_mode, .cfg_wr, .req_func, .req_oe, .req_out, .req_pd, .pad_in, .wake_in,
		.pad_func, .pad_oe, .pad_out, .pad_pd, .pad_ie, .core_in, .wake_out, .rst_src,
		.cfg_hold);
	rps_board_model rps_board_model_inst (.ref_clk, .pad_oe, .pad_out, .pad_pd, .pad_in);

	// Clock at 100 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
		end
	endtask

	// Lets the updates of the last edge land before anything is sampled.
	task automatic cy(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic t_cfg(input logic [N-1:0] f, oe, out, pd);
		@(posedge ref_clk);
		req_func <= f;
		req_oe   <= oe;
		req_out  <= out;
		req_pd   <= pd;
		cfg_wr   <= 1'b1;
		@(posedge ref_clk);
		cfg_wr   <= 1'b0;
		cy(2);
	endtask

	// Power-up reset floats all but the shared pad, then every pad is an input.
	task automatic t_por();
		cy(11);
		chk({pad_oe, pad_ie, pad_pd}, {13'h0000, SH, SH});
		@(posedge ref_clk);
		rst_n <= 1'b1;
		cy(3);
		chk({pad_func, pad_oe, pad_pd, pad_ie}, {39'h0, rps_pkg::PAD_ALL});
		chk(rst_src, rps_pkg::RS_POC);
		chk(cfg_hold, 1'b1);
	endtask

	// Halt acts as run: setups still land and leaving moves no pad.
	task automatic t_halt();
		logic [N-1:0] first_in;
		@(posedge ref_clk);
		pwr_mode <= rps_pkg::PM_HALT;
		t_cfg(DM, OE1, OUT1, SH);
		chk({pad_func, pad_oe, pad_out, pad_pd, pad_ie}, {DM, OE1, OUT1, SH, ~OE1});
		chk(cfg_hold, 1'b0);
		@(posedge ref_clk);
		pwr_mode <= rps_pkg::PM_RUN;
		cy(4);
		chk({pad_func, pad_oe, pad_out, pad_pd, pad_ie}, {DM, OE1, OUT1, SH, ~OE1});
		// Open inputs toggle on the board, so live inputs without pull-down must change every cycle.
		first_in = core_in;
		cy(1);
		chk((first_in ^ core_in) & 13'h001A, 13'h001A);
		chk(core_in & (SH | OE1), 13'h0000);
	endtask

	// A save mode freezes pads and refuses new setups, but wake inputs stay live.
	task automatic t_save(input logic [1:0] mode);
		@(posedge ref_clk);
		pwr_mode <= mode;
		wake_in  <= 20'h5A5A5;
		cy(4);
		chk(wake_out, 20'h5A5A5);
		t_cfg(~DM, ~OE1, ~OUT1, ~SH);
		@(posedge ref_clk);
		wake_in  <= 20'hA5A5A;
		cy(3);
		chk({pad_func, pad_oe, pad_out, pad_pd}, {DM, OE1, OUT1, SH});
		chk(core_in, 13'h0000);
		chk(wake_out, 20'hA5A5A);
		@(posedge ref_clk);
		{req_func, req_oe, req_out, req_pd} <= {DM, OE1, OUT1, SH};
		pwr_mode <= rps_pkg::PM_RUN;
		cy(4);
		chk({pad_func, pad_oe, pad_out, pad_pd, pad_ie}, {DM, OE1, OUT1, SH, ~OE1});
	endtask

	// Internal reset keeps the debug port as it was and frees the port pads.
	task automatic t_int();
		@(posedge ref_clk);
		int_reset <= 1'b1;
		cy(3);
		chk({pad_func, pad_oe, pad_out, pad_pd} & {4{DM}}, {DM, OE1 & DM, OUT1 & DM, SH});
		chk(pad_oe & GM, 13'h0000);
		@(posedge ref_clk);
		int_reset <= 1'b0;
		cy(3);
		chk({pad_func, pad_oe, pad_out, pad_pd} & {4{DM}}, {DM, OE1 & DM, OUT1 & DM, SH});
		chk({pad_ie & GM, pad_oe & GM}, {GM, 13'h0000});
		chk(rst_src, rps_pkg::RS_INT);
		chk(cfg_hold, 1'b1);
	endtask

	// Pin reset or power-on-clear, then the release setup of that source.
	task automatic rst_case(input int which, input logic [N-1:0] f, oe, ie, pd,
			input rps_pkg::rps_rsrc_e src);
		@(posedge ref_clk);
		if (which == 0)
			ext_reset <= 1'b1;
		else
			poc_reset <= 1'b1;
		cy(3);
		chk({pad_oe, pad_ie, pad_pd}, {13'h0000, SH, SH});
		@(posedge ref_clk);
		ext_reset <= 1'b0;
		poc_reset <= 1'b0;
		cy(3);
		chk({pad_func, pad_oe, pad_ie, pad_pd}, {f, oe, ie, pd});
		chk({pad_ie & GM, pad_oe & GM}, {GM, 13'h0000});
		chk(rst_src, src);
	endtask

	// Main sequence; every input starts at a known value.
	initial begin
		mismatches  = 0;
		comparisons = 0;
		rst_n       = 1'b0;
		ext_reset   = 1'b0;
		poc_reset   = 1'b0;
		int_reset   = 1'b0;
		cfg_wr      = 1'b0;
		pwr_mode    = rps_pkg::PM_RUN;
		{req_func, req_oe, req_out, req_pd} = 52'h0;
		wake_in     = 20'h00000;
		t_por();
		t_halt();
		t_save(rps_pkg::PM_IDLE);
		t_save(rps_pkg::PM_STOP);
		t_int();
		rst_case(0, DM, rps_pkg::DDO_MASK, ~rps_pkg::DDO_MASK, SH, rps_pkg::RS_EXT);
		t_cfg(DM, OE1, OUT1, SH);
		rst_case(1, 13'h0000, 13'h0000, rps_pkg::PAD_ALL, 13'h0000, rps_pkg::RS_POC);
		complete_run();
	end

	// A hang counts as a mismatch and ends the run.
	initial begin
		#200000;
		mismatches++;
		complete_run();
	end
endmodule
